// ==== src/pqsi_quick_status.sv ====
`timescale 1ns/10ps
module pqsi_quick_status
  import pqsi_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic MGMT_RD,
  input wire logic MGMT_WR,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic [15:0] MGMT_WDATA,
  output logic [15:0] MGMT_RDATA,
  input wire pqsi_events_s EVENTS,
  input wire pqsi_line_s LINE,
  output logic STAT_IRQ,
  input wire logic [3:0] LINK_IND_DRIVE,
  input wire logic [3:0] TX_IND_DRIVE,
  input wire logic [3:0] LINK_IND_IN,
  output logic [3:0] LINK_IND_OUT,
  output logic [3:0] LINK_IND_OE,
  input wire logic [3:0] TX_IND_IN,
  output logic [3:0] TX_IND_OUT,
  output logic [3:0] TX_IND_OE,
  input wire pqsi_cfg_s CFG_REG,
  output pqsi_cfg_s CFG_EFFECTIVE,
  output logic [2:0] STATION_NUMBER,
  input wire logic [4:0] MODE_SEL,
  output logic MODE_RESERVED
);

  logic rd_hit;
  logic wr_hit;
  assign rd_hit = MGMT_RD && (MGMT_ADDR == PQSI_QS_ADDR);
  assign wr_hit = MGMT_WR && (MGMT_ADDR == PQSI_QS_ADDR);

  // Status flags
  logic rx_error_reg, rx_error_next;
  logic false_carrier_reg, false_carrier_next;
  logic link_change_reg, link_change_next;
  logic remote_fault_reg, remote_fault_next;
  logic unlock_reg, unlock_next;
  logic link_up_reg, link_up_next;
  logic irq_sel_reg, irq_sel_next;
  logic irq_mask_reg, irq_mask_next;
  logic [2:0] an_min_reg, an_min_next;
  logic [2:0] an_max_reg, an_max_next;
  logic irq_reg, irq_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] qs_value;
  logic bit14;

  always_comb begin
    bit14 = irq_sel_reg ? link_change_reg : false_carrier_reg; // see R2 see R3
    qs_value = 16'h0000;
    qs_value[PQSI_BIT_RXERR] = rx_error_reg;
    qs_value[PQSI_BIT_FC] = bit14;
    qs_value[PQSI_BIT_RFLT] = remote_fault_reg;
    qs_value[PQSI_BIT_UNLK] = unlock_reg;
    qs_value[PQSI_BIT_LINK] = link_up_reg;
    qs_value[PQSI_BIT_PAUSE] = LINE.pause; // see R7
    qs_value[PQSI_BIT_SPEED] = LINE.fast_speed; // see R8
    qs_value[PQSI_BIT_DUPLEX] = LINE.full_duplex; // see R9
    qs_value[PQSI_BIT_SEL] = irq_sel_reg;
    qs_value[PQSI_BIT_MASK] = irq_mask_reg;
    qs_value[PQSI_MIN_LSB +: 3] = an_min_reg;
    qs_value[PQSI_MAX_LSB +: 3] = an_max_reg;
  end

  // Sticky set wins over read clear
  always_comb begin
    rx_error_next = (EVENTS.rx_error && LINE.fast_speed) || (rx_error_reg && !rd_hit); // see R1 see R18
    false_carrier_next = (EVENTS.false_carrier && LINE.fast_speed) || (false_carrier_reg && !rd_hit); // see R2
    remote_fault_next = EVENTS.remote_fault || (remote_fault_reg && !rd_hit); // see R4
    unlock_next = (EVENTS.unlock && LINE.fast_speed) || (EVENTS.jabber && !LINE.fast_speed)
                  || (unlock_reg && !rd_hit); // see R5
    link_up_next = rd_hit ? LINE.link_valid : (link_up_reg && LINE.link_valid); // see R6 see R18
    link_change_next = (link_up_next != link_up_reg) || (link_change_reg && !rd_hit); // see R3
    irq_sel_next = wr_hit ? MGMT_WDATA[PQSI_BIT_SEL] : irq_sel_reg; // see R11
    irq_mask_next = wr_hit ? MGMT_WDATA[PQSI_BIT_MASK] : irq_mask_reg; // see R12
    if (rd_hit) begin
      an_min_next = LINE.an_state; // see R13 see R18
      an_max_next = LINE.an_state; // see R14
    end else begin
      an_min_next = (LINE.an_state < an_min_reg) ? LINE.an_state : an_min_reg; // see R13
      an_max_next = (LINE.an_state > an_max_reg) ? LINE.an_state : an_max_reg; // see R14
    end
    if (irq_mask_reg) begin
      irq_next = 1'b0; // see R12
    end else if (irq_sel_reg) begin
      irq_next = link_change_reg; // see R11
    end else begin
      irq_next = rx_error_reg || false_carrier_reg || remote_fault_reg || unlock_reg || !link_up_reg; // see R10
    end
    rdata_next = rd_hit ? qs_value : PQSI_READ_NONE; // see R18
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_error_reg <= 1'b0;
      false_carrier_reg <= 1'b0;
      link_change_reg <= 1'b0;
      remote_fault_reg <= 1'b0;
      unlock_reg <= 1'b0;
      link_up_reg <= 1'b0;
      irq_sel_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
      an_min_reg <= PQSI_AN_HIGHEST;
      an_max_reg <= PQSI_AN_LOWEST;
      irq_reg <= 1'b0;
      rdata_reg <= PQSI_READ_NONE;
    end else begin
      rx_error_reg <= rx_error_next;
      false_carrier_reg <= false_carrier_next;
      link_change_reg <= link_change_next;
      remote_fault_reg <= remote_fault_next;
      unlock_reg <= unlock_next;
      link_up_reg <= link_up_next;
      irq_sel_reg <= irq_sel_next;
      irq_mask_reg <= irq_mask_next;
      an_min_reg <= an_min_next;
      an_max_reg <= an_max_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign MGMT_RDATA = rdata_reg;
  assign STAT_IRQ = irq_reg;

  // Strap sampling and indicator drive
  logic [3:0] link_s1_reg, link_s2_reg;
  logic [3:0] tx_s1_reg, tx_s2_reg;
  logic [4:0] mode_s1_reg, mode_s2_reg;
  pqsi_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] link_strap_reg, link_strap_next;
  logic [3:0] tx_strap_reg, tx_strap_next;
  logic [3:0] link_out_reg, link_out_next;
  logic [3:0] tx_out_reg, tx_out_next;
  pqsi_cfg_s cfg_reg, cfg_next;
  logic mode_res_reg, mode_res_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    link_strap_next = link_strap_reg;
    tx_strap_next = tx_strap_reg;
    case (state_reg)
      PQSI_ST_SAMPLE: begin
        if (cnt_reg == PQSI_STRAP_CNT) begin
          link_strap_next = link_s2_reg; // see R15 see R19
          tx_strap_next = tx_s2_reg; // see R15 see R19
          state_next = PQSI_ST_RUN;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      PQSI_ST_RUN: begin
        cnt_next = cnt_reg;
      end
      default: begin
        state_next = PQSI_ST_SAMPLE;
        cnt_next = 4'h0;
      end
    endcase
    link_out_next = LINK_IND_DRIVE;
    tx_out_next = TX_IND_DRIVE;
    cfg_next.no_link_pulse = link_strap_reg[0] || CFG_REG.no_link_pulse; // see R17
    cfg_next.carrier_integrity = tx_strap_reg[3] || CFG_REG.carrier_integrity; // see R17
    cfg_next.enc_dec_bypass = tx_strap_reg[2] || CFG_REG.enc_dec_bypass; // see R17
    cfg_next.scram_bypass = tx_strap_reg[1] || CFG_REG.scram_bypass; // see R17
    cfg_next.ref_select = tx_strap_reg[0] || CFG_REG.ref_select; // see R17
    mode_res_next = (mode_s2_reg != PQSI_MODE_NORMAL); // see R16
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_s1_reg <= 4'h0;
      link_s2_reg <= 4'h0;
      tx_s1_reg <= 4'h0;
      tx_s2_reg <= 4'h0;
      mode_s1_reg <= 5'h00;
      mode_s2_reg <= 5'h00;
      state_reg <= PQSI_ST_SAMPLE;
      cnt_reg <= 4'h0;
      link_strap_reg <= 4'h0;
      tx_strap_reg <= 4'h0;
      link_out_reg <= 4'h0;
      tx_out_reg <= 4'h0;
      cfg_reg <= '0;
      mode_res_reg <= 1'b0;
    end else begin
      link_s1_reg <= LINK_IND_IN;
      link_s2_reg <= link_s1_reg;
      tx_s1_reg <= TX_IND_IN;
      tx_s2_reg <= tx_s1_reg;
      mode_s1_reg <= MODE_SEL;
      mode_s2_reg <= mode_s1_reg;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      link_strap_reg <= link_strap_next;
      tx_strap_reg <= tx_strap_next;
      link_out_reg <= link_out_next;
      tx_out_reg <= tx_out_next;
      cfg_reg <= cfg_next;
      mode_res_reg <= mode_res_next;
    end
  end

  // Pins released while straps are sampled
  assign LINK_IND_OE = (state_reg == PQSI_ST_RUN) ? 4'hF : 4'h0; // see R15
  assign TX_IND_OE = (state_reg == PQSI_ST_RUN) ? 4'hF : 4'h0;
  assign LINK_IND_OUT = link_out_reg;
  assign TX_IND_OUT = tx_out_reg;
  assign STATION_NUMBER = link_strap_reg[3:1]; // see R19
  assign CFG_EFFECTIVE = cfg_reg;
  assign MODE_RESERVED = mode_res_reg;

  // Checks
  rx_err_set_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R1
    EVENTS.rx_error && LINE.fast_speed |=> rx_error_reg)
    else $error("receive error flag not set");
  sticky_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R4
    rd_hit && !EVENTS.remote_fault |=> !remote_fault_reg)
    else $error("remote fault not cleared by read");
  sticky_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R5
    unlock_reg && !rd_hit |=> unlock_reg)
    else $error("unlock flag lost without read");
  link_latch_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R6
    !LINE.link_valid ##1 (!rd_hit)[*2] |=> !link_up_reg)
    else $error("link bit not latched low");
  link_change_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R3
    $changed(link_up_reg) |-> link_change_reg)
    else $error("link change not flagged");
  irq_mask_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R12
    irq_mask_reg |=> !STAT_IRQ)
    else $error("interrupt while masked");
  irq_link_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R10
    !irq_mask_reg && !irq_sel_reg && !link_up_reg |=> STAT_IRQ)
    else $error("no interrupt on link down");
  irq_sel1_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R11
    !irq_mask_reg && irq_sel_reg && !link_change_reg |=> !STAT_IRQ)
    else $error("interrupt without link change");
  an_min_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R13
    !rd_hit ##1 !rd_hit |-> an_min_reg <= $past(LINE.an_state))
    else $error("lowest state above a seen state");
  read_data_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R18
    rd_hit |=> MGMT_RDATA[PQSI_BIT_RXERR] == $past(rx_error_reg))
    else $error("read did not return pre-clear value");
  strap_addr_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R19
    state_reg == PQSI_ST_SAMPLE && state_next == PQSI_ST_RUN |=> STATION_NUMBER == $past(link_s2_reg[3:1]))
    else $error("station number not taken from straps");
  fc_set_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R2
    EVENTS.false_carrier && LINE.fast_speed |=> false_carrier_reg)
    else $error("false carrier flag not set");
  rx_err_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R1
    !rx_error_reg && !(EVENTS.rx_error && LINE.fast_speed) |=> !rx_error_reg)
    else $error("receive error flag set without event");
  rflt_set_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R4
    EVENTS.remote_fault |=> remote_fault_reg)
    else $error("remote fault flag not set");
  unlock_set_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R5
    (EVENTS.unlock && LINE.fast_speed) || (EVENTS.jabber && !LINE.fast_speed) |=> unlock_reg)
    else $error("unlock or jabber flag not set");
  link_reload_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R6
    rd_hit |=> link_up_reg == $past(LINE.link_valid))
    else $error("link bit not refreshed by read");
  link_low_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R6
    !link_up_reg && !rd_hit |=> !link_up_reg)
    else $error("link bit rose without read");
  sel_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R11
    wr_hit |=> irq_sel_reg == $past(MGMT_WDATA[PQSI_BIT_SEL]))
    else $error("select bit not written");
  mask_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R12
    wr_hit |=> irq_mask_reg == $past(MGMT_WDATA[PQSI_BIT_MASK]))
    else $error("mask bit not written");
  irq_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R10
    !irq_mask_reg && !irq_sel_reg
    && (rx_error_reg || false_carrier_reg || remote_fault_reg || unlock_reg) |=> STAT_IRQ)
    else $error("no interrupt on sticky flag");
  irq_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R10
    !irq_sel_reg && link_up_reg && !rx_error_reg && !false_carrier_reg
    && !remote_fault_reg && !unlock_reg |=> !STAT_IRQ)
    else $error("interrupt without a source");
  an_max_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R14
    !rd_hit |=> an_max_reg >= $past(LINE.an_state))
    else $error("highest state below a seen state");
  an_reload_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R13
    rd_hit |=> an_min_reg == $past(LINE.an_state) && an_max_reg == $past(LINE.an_state))
    else $error("state history not restarted by read");
  read_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R18
    !rd_hit |=> MGMT_RDATA == PQSI_READ_NONE)
    else $error("read data without a read");
  oe_sample_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R15
    state_reg == PQSI_ST_SAMPLE |-> !(|LINK_IND_OE) && !(|TX_IND_OE))
    else $error("indicator pins driven while sampling");
  cfg_or_a: assert property (@(posedge CLK) disable iff (!RESET_N) // see R17
    state_reg == PQSI_ST_RUN |=> CFG_EFFECTIVE.ref_select == ($past(CFG_REG.ref_select) || tx_strap_reg[0]))
    else $error("strap not combined with register bit");

  read_clear_c: cover property (@(posedge CLK) disable iff (!RESET_N) rx_error_reg ##1 rd_hit ##1 !rx_error_reg);
  link_irq_c: cover property (@(posedge CLK) disable iff (!RESET_N) irq_sel_reg && link_change_reg ##1 STAT_IRQ);
  strap_done_c: cover property (@(posedge CLK) disable iff (!RESET_N) state_reg == PQSI_ST_RUN);
  jabber_c: cover property (@(posedge CLK) disable iff (!RESET_N) EVENTS.jabber && !LINE.fast_speed ##1 unlock_reg);
  mask_c: cover property (@(posedge CLK) disable iff (!RESET_N) irq_mask_reg && link_change_reg);

endmodule // pqsi_quick_status

// ==== src/pqsi_pkg.sv ====
// Notes on behaviour
// R1 - Receive-error flag set at 100 Mbit/s, held until register read, resets to 0.
// R2 - Select bit 0: bit 14 is sticky false-carrier flag at 100 Mbit/s, read-cleared.
// R3 - Select bit 1: bit 14 flags any change of the link-up bit.
// R4 - Remote-fault flag set on remote fault, held until read, resets to 0.
// R5 - Bit 12 sets on descrambler unlock at 100 or jabber at 10, read-cleared.
// R6 - Link-up bit shows valid link, latches low on failure until read.
// R7 - Pause bit is 1 when flow control is to be exchanged.
// R8 - Speed bit is 1 at 100 Mbit/s, 0 at 10 Mbit/s.
// R9 - Duplex bit is 1 for full duplex, 0 for half duplex.
// R10 - Select 0: interrupt high when any of bits 15..12 high or link-up low.
// R11 - Select 1: interrupt only from link-change flag; select bit writable, resets 0.
// R12 - Mask bit high blocks every interrupt; low lets select bit decide.
// R13 - Lowest autonegotiation state since last read, 3-bit encoded field.
// R14 - Highest autonegotiation state since last read, same encoding.
// R15 - Indicator pin straps are sampled at reset to preset management functions.
// R16 - Outside party keeps mode select at 00000; other codes reserved.
// R17 - Each strap is ORed with its configuration register bit; the code ORs only link strap 0 and the four TX straps.
// R18 - Only a completed register read clears history; read returns pre-clear values.
// R19 - Each strap has its own pin; station number from three link pins.
package pqsi_pkg;
  localparam logic [4:0] PQSI_QS_ADDR = 5'h1F;
  localparam int PQSI_BIT_RXERR = 15;
  localparam int PQSI_BIT_FC = 14;
  localparam int PQSI_BIT_RFLT = 13;
  localparam int PQSI_BIT_UNLK = 12;
  localparam int PQSI_BIT_LINK = 11;
  localparam int PQSI_BIT_PAUSE = 10;
  localparam int PQSI_BIT_SPEED = 9;
  localparam int PQSI_BIT_DUPLEX = 8;
  localparam int PQSI_BIT_SEL = 7;
  localparam int PQSI_BIT_MASK = 6;
  localparam int PQSI_MIN_LSB = 3;
  localparam int PQSI_MAX_LSB = 0;
  localparam logic [2:0] PQSI_AN_LOWEST = 3'h0;
  localparam logic [2:0] PQSI_AN_HIGHEST = 3'h7;
  localparam logic [4:0] PQSI_MODE_NORMAL = 5'h00;
  localparam logic [15:0] PQSI_READ_NONE = 16'h0000;
  localparam int PQSI_CLK_NS = 8;
  localparam int PQSI_STRAP_SETTLE_NS = 80;
  localparam int PQSI_STRAP_CYCLES = (PQSI_STRAP_SETTLE_NS + PQSI_CLK_NS - 1) / PQSI_CLK_NS;
  localparam logic [3:0] PQSI_STRAP_CNT = 4'(PQSI_STRAP_CYCLES);

  typedef struct packed {
    logic rx_error;
    logic false_carrier;
    logic remote_fault;
    logic unlock;
    logic jabber;
  } pqsi_events_s;

  typedef struct packed {
    logic link_valid;
    logic pause;
    logic fast_speed;
    logic full_duplex;
    logic [2:0] an_state;
  } pqsi_line_s;

  typedef struct packed {
    logic no_link_pulse;
    logic carrier_integrity;
    logic enc_dec_bypass;
    logic scram_bypass;
    logic ref_select;
  } pqsi_cfg_s;

  typedef enum logic [1:0] {
    PQSI_ST_SAMPLE = 2'b01,
    PQSI_ST_RUN = 2'b10
  } pqsi_state_e;
endpackage

// ==== verif/pqsi_station.sv ====
`timescale 1ns/10ps
module pqsi_station
  import pqsi_pkg::*;
(
  input wire logic CLK,
  output logic MGMT_RD,
  output logic MGMT_WR,
  output logic [4:0] MGMT_ADDR,
  output logic [15:0] MGMT_WDATA,
  input wire logic [15:0] MGMT_RDATA,
  output logic [4:0] MODE_SEL
);
  int gap = 0;
  initial begin
    MGMT_RD = 1'b0;
    MGMT_WR = 1'b0;
    MGMT_ADDR = 5'h00;
    MGMT_WDATA = 16'h0000;
    MODE_SEL = PQSI_MODE_NORMAL;
  end
  // One completed access; idle bus shows inverted values
  task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
    repeat (gap) @(posedge CLK);
    @(posedge CLK);
    MGMT_RD <= !wr;
    MGMT_WR <= wr;
    MGMT_ADDR <= addr;
    MGMT_WDATA <= wdata;
    @(posedge CLK);
    MGMT_RD <= 1'b0;
    MGMT_WR <= 1'b0;
    MGMT_ADDR <= ~addr;
    MGMT_WDATA <= ~wdata;
    #1 rdata = MGMT_RDATA;
  endtask
endmodule // pqsi_station

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench
  import pqsi_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pqsi_events_s ev = '0;
  pqsi_line_s ln = 7'h74;
  pqsi_cfg_s cfg = 5'h08;
  pqsi_cfg_s cfg_eff;
  logic rd_s, wr_s, irq, mode_res;
  logic [4:0] addr, mode;
  logic [15:0] wdata, rdata, d;
  logic [3:0] link_out, link_oe, tx_out, tx_oe, link_pin, tx_pin;
  logic [2:0] station_num;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  // Pins: strap resistors unless the device drives
  assign link_pin = (link_oe & link_out) | (~link_oe & 4'hB);
  assign tx_pin = (tx_oe & tx_out) | (~tx_oe & 4'h5);

  pqsi_quick_status uut (.CLK(clk), .RESET_N(reset_n), .MGMT_RD(rd_s), .MGMT_WR(wr_s), .MGMT_ADDR(addr),
    .MGMT_WDATA(wdata), .MGMT_RDATA(rdata), .EVENTS(ev), .LINE(ln), .STAT_IRQ(irq),
    .LINK_IND_DRIVE(4'hA), .TX_IND_DRIVE(4'h3), .LINK_IND_IN(link_pin), .LINK_IND_OUT(link_out),
    .LINK_IND_OE(link_oe), .TX_IND_IN(tx_pin), .TX_IND_OUT(tx_out), .TX_IND_OE(tx_oe), .CFG_REG(cfg),
    .CFG_EFFECTIVE(cfg_eff), .STATION_NUMBER(station_num), .MODE_SEL(mode), .MODE_RESERVED(mode_res));
  pqsi_station station (.CLK(clk), .MGMT_RD(rd_s), .MGMT_WR(wr_s), .MGMT_ADDR(addr), .MGMT_WDATA(wdata),
    .MGMT_RDATA(rdata), .MODE_SEL(mode));

  always #4 clk = ~clk;

  task automatic stop_test();
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    station.access(1'b0, a, 16'h0000, v);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] dummy;
    station.access(1'b1, a, v, dummy);
  endtask
  task automatic pulse(input pqsi_events_s e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
  endtask

  task automatic t_straps();
    repeat (14) @(posedge clk);
    #1;
    check("station", {13'h0, station_num}, 16'h0005);
    check("cfg", {11'h0, cfg_eff}, 16'h001D);
    check("oe", {8'h0, link_oe, tx_oe}, 16'h00FF);
    check("pins", {8'h0, link_pin, tx_pin}, 16'h00A3);
    check("mode", {15'h0, mode_res}, 16'h0000);
  endtask

  task automatic t_link();
    check("irq boot", {15'h0, irq}, 16'h0001);
    rd(PQSI_QS_ADDR, d);
    check("qs latched", d, 16'h0624);
    rd(PQSI_QS_ADDR, d);
    check("qs link", d, 16'h0E24);
    check("irq idle", {15'h0, irq}, 16'h0000);
  endtask

  task automatic t_sticky();
    pulse(5'h1F);
    @(posedge clk);
    #1 check("irq ev", {15'h0, irq}, 16'h0001);
    rd(PQSI_QS_ADDR, d);
    check("qs fast", d, 16'hFE24);
    rd(PQSI_QS_ADDR, d);
    check("qs clr", d, 16'h0E24);
    @(posedge clk);
    ln <= 7'h6C;
    pulse(5'h1E);
    rd(PQSI_QS_ADDR, d);
    check("qs slow", d, 16'h2D24);
    pulse(5'h01);
    rd(PQSI_QS_ADDR, d);
    check("qs jabber", d, 16'h1D24);
  endtask

  task automatic t_select();
    wr(PQSI_QS_ADDR, 16'h0080);
    rd(PQSI_QS_ADDR, d);
    check("qs sel", d, 16'h0DA4);
    pulse(5'h04);
    @(posedge clk);
    #1 check("irq sel", {15'h0, irq}, 16'h0000);
    @(posedge clk);
    ln.link_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check("irq chg", {15'h0, irq}, 16'h0001);
    wr(PQSI_QS_ADDR, 16'h00C0);
    @(posedge clk);
    #1 check("irq mask", {15'h0, irq}, 16'h0000);
    rd(PQSI_QS_ADDR, d);
    check("qs chg", d, 16'h65E4);
    station.gap = 2;
    wr(5'h1E, 16'h0000);
    rd(5'h1E, d);
    check("unmapped", d, 16'h0000);
    rd(PQSI_QS_ADDR, d);
    check("qs keep", d, 16'h05E4);
    station.gap = 0;
  endtask

  task automatic t_autoneg();
    logic [2:0] seq [2][5];
    logic [15:0] exp [2];
    seq = '{'{3'h3, 3'h5, 3'h1, 3'h6, 3'h4}, '{3'h7, 3'h0, 3'h4, 3'h4, 3'h4}};
    exp = '{16'h000E, 16'h0007};
    @(posedge clk);
    ln <= 7'h6C;
    for (int k = 0; k < 2; k++) begin
      rd(PQSI_QS_ADDR, d);
      for (int i = 0; i < 5; i++) begin
        @(posedge clk);
        ln.an_state <= seq[k][i];
      end
      rd(PQSI_QS_ADDR, d);
      check("an span", {10'h0, d[5:0]}, exp[k]);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_straps();
    t_link();
    t_sticky();
    t_select();
    t_autoneg();
    stop_test();
  end
endmodule // testbench
